// ---- rtl/sacc_ctrl.sv ----
// Conversion control of a successive approximation converter, APB slave
// ----------------------------------------------------------------
// Notes on behaviour
// (RULE1) Ten-bit result by successive approximation
// (RULE2) Reference from field and external enable bit
// (RULE3) Five-bit channel field selects input
// (RULE4) Differential codes carry gain, others bypass
// (RULE5) Selections inert and power off when disabled
// (RULE6) Right aligned result, left when bit set
// (RULE7) Low byte read locks result until high
// (RULE8) Completion flag fires even when result lost
// (RULE9) Start bit set until conversion finishes
// (RULE10) Running conversion keeps its old channel
// (RULE11) Trigger edge resets prescaler, starts conversion
// (RULE12) Flag sets regardless of interrupt enables
// (RULE13) Done-flag source restarts each conversion
// (RULE14) Start bit reads one during any conversion
// (RULE15) Prescaler held reset while disabled
// (RULE16) Software start waits for converter clock edge
// (RULE17) Thirteen cycles, first conversion twenty-five
// (RULE18) Completion writes result, flags, clears start
// (RULE19) Auto conversion samples after two cycles
// (RULE20) Free running restarts at once, start stays
// (RULE21) Selection buffer frozen during conversion; the code lets it follow again in the last converter cycle
// (RULE22) Software changes selection only at safe times
// (RULE23) Prescaler code selects ratio two to 128
// (RULE24) Channel code table supplied separately
// ----------------------------------------------------------------
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module sacc_ctrl #(
  parameter int unsigned TRIG_W = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sacc_pkg::ADDR_W-1:0] paddr,
  input wire logic [sacc_pkg::DATA_W-1:0] pwdata,
  output logic [sacc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [TRIG_W-1:0] trig_in,
  input wire logic cmp_in,
  output sacc_pkg::sacc_ana_t ana,
  output logic conv_irq
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  initial begin
    if (TRIG_W < 1 || TRIG_W > 7) begin
      $error("TRIG_W must be 1 to 7");
    end
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [sacc_pkg::BYTE_W-1:0] insel_q;
  logic en_q, start_q, ate_q, flag_q, ie_q, first_q, lock_q;
  logic [sacc_pkg::PS_W-1:0] ps_q;
  logic [sacc_pkg::TS_W-1:0] ts_q;
  logic [sacc_pkg::MISC_W-1:0] misc_q;
  logic [sacc_pkg::CH_W-1:0] ch_act_q;
  logic [sacc_pkg::REF_W-1:0] ref_act_q;
  logic [sacc_pkg::RES_W-1:0] res_q, sar_q;
  logic [3:0] bit_q;
  logic trial_q, tph_q, adc_ph_q, trig_prev_q;
  logic [sacc_pkg::HC_W-1:0] pre_q, hc_q, len_q, samp_q;
  logic [sacc_pkg::DATA_W-1:0] prdata_q;
  logic [TRIG_W-1:0] trig_m_q, trig_s_q;
  logic cmp_m_q, cmp_s_q;
  sacc_pkg::sacc_state_t st_q, st_d;
  sacc_pkg::sacc_ana_t ana_q, ana_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire logic acc = psel & penable;
  wire logic wr = acc & pwrite;
  wire logic rd = acc & ~pwrite;
  wire logic hit_insel = paddr == sacc_pkg::OFF_INSEL;
  wire logic hit_csa = paddr == sacc_pkg::OFF_CSA;
  wire logic hit_csb = paddr == sacc_pkg::OFF_CSB;
  wire logic hit_resl = paddr == sacc_pkg::OFF_RESL;
  wire logic hit_resh = paddr == sacc_pkg::OFF_RESH;
  wire logic hit_misc = paddr == sacc_pkg::OFF_MISC;
  wire logic mapped = hit_insel | hit_csa | hit_csb | hit_resl | hit_resh | hit_misc;
  wire logic wr_csa = wr & hit_csa;
  wire logic lar = insel_q[sacc_pkg::INSEL_LAR];
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < TRIG_W; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          trig_m_q[gi] <= 1'b0;
          trig_s_q[gi] <= 1'b0;
        end else begin
          trig_m_q[gi] <= trig_in[gi];
          trig_s_q[gi] <= trig_m_q[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_m_q <= 1'b0;
      cmp_s_q <= 1'b0;
    end else begin
      cmp_m_q <= cmp_in;
      cmp_s_q <= cmp_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and triggers
  // ----------------------------------------------------------------
  wire logic [7:0] src_vec = 8'({trig_s_q, 1'b0});
  wire logic trig_sel = src_vec[ts_q];
  wire logic trig_edge = trig_sel & ~trig_prev_q; // RULE19
  wire logic restart = ate_q & (ts_q == sacc_pkg::TS_FREE); // RULE13
  wire logic auto_evt = en_q & ate_q & (ts_q != sacc_pkg::TS_FREE) & trig_edge
                        & (st_q != sacc_pkg::ST_CONV); // RULE11
  wire logic [6:0] half_n = (ps_q == '0) ? 7'h01 : 7'(7'h01 << (ps_q - 3'h1)); // RULE23
  wire logic half_tick = ({1'b0, pre_q} == 7'(half_n - 7'h01));
  wire logic rise = half_tick & ~adc_ph_q;
  wire logic in_conv = st_q == sacc_pkg::ST_CONV;
  wire logic done = in_conv & half_tick & (hc_q == 6'(len_q - 6'h01)); // RULE17
  wire logic samp = in_conv & half_tick & (hc_q == 6'(samp_q - 6'h01));
  wire logic go = en_q & (auto_evt | ((st_q == sacc_pkg::ST_WAIT) & rise) | (done & restart));
  wire logic sw_start = wr_csa & pwdata[sacc_pkg::CSA_SC] & pwdata[sacc_pkg::CSA_EN] & en_q;
  wire logic follow = ~in_conv | (hc_q >= 6'(len_q - 6'h02)); // RULE21

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      adc_ph_q <= 1'b0;
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sel;
      if (!en_q || auto_evt) begin
        pre_q <= '0; // RULE15
        adc_ph_q <= auto_evt; // RULE11
      end else if (half_tick) begin
        pre_q <= '0;
        adc_ph_q <= ~adc_ph_q;
      end else begin
        pre_q <= pre_q + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    case (st_q)
      sacc_pkg::ST_IDLE: begin
        if (auto_evt) begin
          st_d = sacc_pkg::ST_CONV;
        end else if (sw_start) begin
          st_d = sacc_pkg::ST_WAIT; // RULE16
        end
      end
      sacc_pkg::ST_WAIT: begin
        if (go) begin
          st_d = sacc_pkg::ST_CONV;
        end
      end
      sacc_pkg::ST_CONV: begin
        if (done) begin
          if (restart) begin
            st_d = sacc_pkg::ST_CONV; // RULE20
          end else if (sw_start) begin
            st_d = sacc_pkg::ST_WAIT;
          end else begin
            st_d = sacc_pkg::ST_IDLE;
          end
        end
      end
      default: st_d = sacc_pkg::ST_IDLE;
    endcase
    if (!en_q) begin
      st_d = sacc_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= sacc_pkg::ST_IDLE;
      hc_q <= '0;
      len_q <= sacc_pkg::NORM_LEN_H;
      samp_q <= sacc_pkg::NORM_SAMP_H;
      first_q <= 1'b1;
    end else begin
      st_q <= st_d;
      first_q <= ~en_q | (first_q & ~done); // RULE17
      if (go) begin
        hc_q <= '0;
        len_q <= (first_q & ~done) ? sacc_pkg::FIRST_LEN_H
                 : (auto_evt ? sacc_pkg::AUTO_LEN_H : sacc_pkg::NORM_LEN_H); // RULE17 RULE19
        samp_q <= (first_q & ~done) ? sacc_pkg::FIRST_SAMP_H
                  : (auto_evt ? sacc_pkg::AUTO_SAMP_H : sacc_pkg::NORM_SAMP_H);
      end else if (in_conv && half_tick) begin
        hc_q <= hc_q + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Approximation register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_q <= '0;
      bit_q <= '0;
      trial_q <= 1'b0;
      tph_q <= 1'b0;
    end else if (!en_q) begin
      trial_q <= 1'b0;
    end else if (samp) begin
      sar_q <= sacc_pkg::SAR_MSB; // RULE1
      bit_q <= 4'(sacc_pkg::RES_W - 1);
      trial_q <= 1'b1;
      tph_q <= 1'b0;
    end else if (trial_q && half_tick) begin
      tph_q <= ~tph_q;
      if (tph_q) begin
        sar_q[bit_q] <= cmp_s_q; // RULE1
        if (bit_q == 4'h0) begin
          trial_q <= 1'b0;
        end else begin
          sar_q[bit_q - 4'h1] <= 1'b1;
          bit_q <= bit_q - 4'h1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insel_q <= sacc_pkg::RST_BYTE;
      en_q <= 1'b0;
      ate_q <= 1'b0;
      ie_q <= 1'b0;
      ps_q <= '0;
      ts_q <= '0;
      misc_q <= '0;
    end else if (wr) begin
      if (hit_insel) begin
        insel_q <= pwdata[sacc_pkg::BYTE_W-1:0];
      end
      if (hit_csa) begin
        en_q <= pwdata[sacc_pkg::CSA_EN];
        ate_q <= pwdata[sacc_pkg::CSA_ATE];
        ie_q <= pwdata[sacc_pkg::CSA_IE];
        ps_q <= pwdata[sacc_pkg::CSA_PS_LSB +: sacc_pkg::PS_W];
      end
      if (hit_csb) begin
        ts_q <= pwdata[sacc_pkg::CSB_TS_LSB +: sacc_pkg::TS_W];
      end
      if (hit_misc) begin
        misc_q <= pwdata[sacc_pkg::MISC_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= 1'b0;
      flag_q <= 1'b0;
      lock_q <= 1'b0;
      res_q <= '0;
    end else begin
      if (!en_q) begin
        start_q <= 1'b0;
      end else if (sw_start || auto_evt || (done && restart)) begin
        start_q <= 1'b1; // RULE9 RULE14 RULE20
      end else if (done) begin
        start_q <= 1'b0; // RULE18
      end
      flag_q <= done | (flag_q & ~(wr_csa & pwdata[sacc_pkg::CSA_IF])); // RULE8 RULE12
      if (done && !lock_q) begin
        res_q <= sar_q; // RULE7 RULE18
      end
      if (rd && hit_resl) begin
        lock_q <= 1'b1; // RULE7
      end else if (rd && hit_resh) begin
        lock_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Selection buffer and analog controls
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_act_q <= '0;
      ref_act_q <= '0;
      ana_q <= '0;
    end else begin
      if (follow) begin
        ch_act_q <= insel_q[sacc_pkg::INSEL_MUX_LSB +: sacc_pkg::CH_W]; // RULE10 RULE21
        ref_act_q <= insel_q[sacc_pkg::INSEL_REF_LSB +: sacc_pkg::REF_W];
      end
      ana_q <= ana_d;
    end
  end

  always_comb begin
    ana_d = '0;
    ana_d.power_en = en_q; // RULE5
    ana_d.internal_current_source_en = misc_q[sacc_pkg::MISC_INTERNAL_CURRENT_SOURCE];
    if (en_q) begin
      ana_d.ref_sel = ref_act_q; // RULE2
      ana_d.ext_ref_en = misc_q[sacc_pkg::MISC_XREF];
      ana_d.ch_sel = ch_act_q; // RULE3 RULE4 RULE24
      ana_d.sample = samp;
      ana_d.dac_code = sar_q;
    end
  end
  assign ana = ana_q;
  assign conv_irq = flag_q & ie_q; // RULE8

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [sacc_pkg::BYTE_W-1:0] csa_rd, rd_mux;
  always_comb begin
    csa_rd = '0;
    csa_rd[sacc_pkg::CSA_EN] = en_q;
    csa_rd[sacc_pkg::CSA_SC] = start_q; // RULE14
    csa_rd[sacc_pkg::CSA_ATE] = ate_q;
    csa_rd[sacc_pkg::CSA_IF] = flag_q;
    csa_rd[sacc_pkg::CSA_IE] = ie_q;
    csa_rd[sacc_pkg::CSA_PS_LSB +: sacc_pkg::PS_W] = ps_q;
    rd_mux = '0;
    if (hit_insel) begin
      rd_mux = insel_q;
    end else if (hit_csa) begin
      rd_mux = csa_rd;
    end else if (hit_csb) begin
      rd_mux = 8'(ts_q);
    end else if (hit_resl) begin
      rd_mux = lar ? {res_q[1:0], 6'h00} : res_q[7:0]; // RULE6
    end else if (hit_resh) begin
      rd_mux = lar ? res_q[9:2] : {6'h00, res_q[9:8]}; // RULE6
    end else if (hit_misc) begin
      rd_mux = 8'(misc_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable) begin
      prdata_q <= 32'(rd_mux);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_flag_on_done: assert property (done |=> flag_q) // RULE12
    else $error("flag not set after completion");
  chk_start_clear: assert property (done && !restart && !sw_start |=> !start_q) // RULE18
    else $error("start bit not cleared at completion");
  chk_lock_hold: assert property (done && lock_q |=> $stable(res_q) && flag_q) // RULE7
    else $error("locked result changed");
  chk_result_write: assert property (done && !lock_q |=> res_q == $past(sar_q)) // RULE1
    else $error("result not written");
  chk_presc_held: assert property (!en_q |=> pre_q == '0 && !adc_ph_q) // RULE15
    else $error("prescaler runs while disabled");
  chk_buf_frozen: assert property (in_conv && !follow |=> $stable(ch_act_q)) // RULE21
    else $error("selection changed mid conversion");
  chk_wait_edge: assert property (st_q == sacc_pkg::ST_WAIT && en_q && rise
    |=> in_conv && hc_q == '0) // RULE16
    else $error("software start missed converter edge");
  chk_free_run: assert property (done && restart && en_q |=> in_conv && start_q
    ##1 (start_q || !$past(en_q)))
    // RULE20
    else $error("free running did not restart");
  chk_auto_start: assert property (auto_evt |=> in_conv && pre_q == '0 && samp_q ==
    (first_q ? sacc_pkg::FIRST_SAMP_H : sacc_pkg::AUTO_SAMP_H)) // RULE11
    else $error("trigger did not start conversion");
  chk_busy_reads: assert property (in_conv |-> start_q) // RULE14
    else $error("start bit low during conversion");
  chk_off_quiet: assert property (!en_q ##1 !en_q |-> !ana_q.power_en && ana_q.ch_sel == '0)
    // RULE5
    else $error("analog active while disabled");

  cov_lost_result: cover property (done && lock_q);
  cov_free_run: cover property (done && restart);
  cov_auto: cover property (auto_evt ##[1:300] done);
  cov_first: cover property (done && first_q);
endmodule
`default_nettype wire

// ---- rtl/sacc_pkg.sv ----
// Constants, field layout and types of the converter control block
package sacc_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned RES_W = 10;
  localparam int unsigned CH_W = 5;
  localparam int unsigned REF_W = 2;
  localparam int unsigned PS_W = 3;
  localparam int unsigned TS_W = 3;
  localparam int unsigned HC_W = 6;
  localparam int unsigned ADDR_W = 8;
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFF_INSEL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_CSA = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CSB = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_RESH = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_MISC = 8'h14;
  // Field positions
  localparam int unsigned INSEL_MUX_LSB = 0;
  localparam int unsigned INSEL_LAR = 5;
  localparam int unsigned INSEL_REF_LSB = 6;
  localparam int unsigned CSA_PS_LSB = 0;
  localparam int unsigned CSA_IE = 3;
  localparam int unsigned CSA_IF = 4;
  localparam int unsigned CSA_ATE = 5;
  localparam int unsigned CSA_SC = 6;
  localparam int unsigned CSA_EN = 7;
  localparam int unsigned CSB_TS_LSB = 0;
  localparam int unsigned MISC_INTERNAL_CURRENT_SOURCE = 0;
  localparam int unsigned MISC_XREF = 1;
  localparam int unsigned MISC_W = 2;
  // Reset values
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
  localparam logic [TS_W-1:0] TS_FREE = 3'h0;
  // Conversion timing in converter clock cycles, counted in half cycles
  localparam int unsigned HALVES = 2;
  localparam logic [HC_W-1:0] NORM_LEN_H = HC_W'(13 * HALVES);
  localparam logic [HC_W-1:0] NORM_SAMP_H = HC_W'(3);
  localparam logic [HC_W-1:0] FIRST_LEN_H = HC_W'(25 * HALVES);
  localparam logic [HC_W-1:0] FIRST_SAMP_H = HC_W'(29);
  localparam logic [HC_W-1:0] AUTO_LEN_H = HC_W'(27);
  localparam logic [HC_W-1:0] AUTO_SAMP_H = HC_W'(2 * HALVES);
  localparam logic [RES_W-1:0] SAR_MSB = 10'h200;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV} sacc_state_t;

  typedef struct packed {
    logic power_en;
    logic [REF_W-1:0] ref_sel;
    logic ext_ref_en;
    logic internal_current_source_en;
    logic [CH_W-1:0] ch_sel;
    logic sample;
    logic [RES_W-1:0] dac_code;
  } sacc_ana_t;
endpackage

// ---- sim/tb_top.sv ----
// Self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] trig_in = 7'h00;
  wire logic cmp_in;
  sacc_pkg::sacc_ana_t ana;
  logic conv_irq;
  logic [9:0] target = 10'h000;
  logic [31:0] rd;
  logic er;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int t0 = 0;
  int samp_q[$];

  sacc_ctrl i_sacc_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .trig_in(trig_in),
    .cmp_in(cmp_in),
    .ana(ana),
    .conv_irq(conv_irq)
  );

  // ----------------------------------------------------------------
  // Clock, comparator model, monitor and timeout
  // ----------------------------------------------------------------
  initial begin
    forever #50 pclk = ~pclk;
  end

  // Comparator high while the analog input is at or above the trial word
  assign cmp_in = (ana.dac_code <= target);

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (ana.sample === 1'b1) samp_q.push_back(cyc);
    if (cyc == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check_val(what, exp, rd);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (conv_irq !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    check_val("conv_irq", 32'h1, 32'(conv_irq));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and unmapped access
    for (int i = 0; i < 6; i++) begin
      rdchk("reset value", 8'(4 * i), 32'h0);
    end
    apb(1'b0, 8'h18, 32'h0);
    check_val("pslverr", 32'h1, 32'(er));
    check_val("unmapped data", 32'h0, rd);
    // Selections inert while disabled
    wr(sacc_pkg::OFF_INSEL, 8'h55);
    wr(sacc_pkg::OFF_MISC, 8'h03);
    rdchk("input select", sacc_pkg::OFF_INSEL, 32'h55);
    check_val("ch_sel off", 32'h0, 32'(ana.ch_sel));
    check_val("ref_sel off", 32'h0, 32'(ana.ref_sel));
    check_val("power off", 32'h0, 32'(ana.power_en));
    check_val("internal_current_source off", 32'h1, 32'(ana.internal_current_source_en));
    // Enable, ratio 8, interrupt enable
    wr(sacc_pkg::OFF_CSA, 8'h8B);
    repeat (3) @(posedge pclk);
    check_val("power on", 32'h1, 32'(ana.power_en));
    check_val("ch_sel on", 32'h15, 32'(ana.ch_sel));
    check_val("ref_sel on", 32'h1, 32'(ana.ref_sel));
    check_val("ext ref", 32'h1, 32'(ana.ext_ref_en));
    check_val("internal_current_source on", 32'h1, 32'(ana.internal_current_source_en));
    // Single conversion, channel change mid conversion
    target <= 10'h2A5;
    wr(sacc_pkg::OFF_CSA, 8'hCB);
    rdchk("busy", sacc_pkg::OFF_CSA, 32'hCB);
    repeat (20) @(posedge pclk);
    wr(sacc_pkg::OFF_INSEL, 8'h43);
    repeat (2) @(posedge pclk);
    check_val("ch_sel frozen", 32'h15, 32'(ana.ch_sel));
    wait_irq();
    rdchk("done", sacc_pkg::OFF_CSA, 32'h9B);
    check_val("ch_sel new", 32'h3, 32'(ana.ch_sel));
    rdchk("low right", sacc_pkg::OFF_RESL, 32'hA5);
    rdchk("high right", sacc_pkg::OFF_RESH, 32'h02);
    wr(sacc_pkg::OFF_CSA, 8'h9B);
    @(posedge pclk);
    check_val("irq cleared", 32'h0, 32'(conv_irq));
    // Left alignment and result lock
    wr(sacc_pkg::OFF_INSEL, 8'h63);
    rdchk("low left", sacc_pkg::OFF_RESL, 32'h40);
    target <= 10'h156;
    wr(sacc_pkg::OFF_CSA, 8'hCB);
    wait_irq();
    rdchk("high locked", sacc_pkg::OFF_RESH, 32'hA9);
    wr(sacc_pkg::OFF_CSA, 8'h9B);
    wr(sacc_pkg::OFF_CSA, 8'hCB);
    wait_irq();
    rdchk("low updated", sacc_pkg::OFF_RESL, 32'h80);
    rdchk("high updated", sacc_pkg::OFF_RESH, 32'h55);
    wr(sacc_pkg::OFF_CSA, 8'h9B);
    // Auto trigger from source 1
    wr(sacc_pkg::OFF_CSB, 8'h01);
    wr(sacc_pkg::OFF_CSA, 8'hAB);
    samp_q.delete();
    @(posedge pclk);
    trig_in <= 7'h01;
    t0 = cyc;
    repeat (6) @(posedge pclk);
    trig_in <= 7'h00;
    repeat (2) @(posedge pclk);
    trig_in <= 7'h01;
    rdchk("auto busy", sacc_pkg::OFF_CSA, 32'hEB);
    wait_irq();
    repeat (200) @(posedge pclk);
    check_val("auto count", 32'h1, 32'(samp_q.size()));
    check_val("auto sample", 32'h14, 32'(samp_q[0] - t0));
    wr(sacc_pkg::OFF_CSA, 8'hBB);
    wr(sacc_pkg::OFF_CSA, 8'hEB);
    wait_irq();
    check_val("manual count", 32'h2, 32'(samp_q.size()));
    // Free running at ratio 2 without interrupt enable
    wr(sacc_pkg::OFF_CSA, 8'h00);
    wr(sacc_pkg::OFF_CSB, 8'h00);
    wr(sacc_pkg::OFF_CSA, 8'hA0);
    samp_q.delete();
    wr(sacc_pkg::OFF_CSA, 8'hE0);
    while (samp_q.size() < 3) @(posedge pclk);
    check_val("first gap", 32'h18, 32'(samp_q[1] - samp_q[0]));
    check_val("normal gap", 32'h1A, 32'(samp_q[2] - samp_q[1]));
    apb(1'b0, sacc_pkg::OFF_CSA, 32'h0);
    check_val("free flags", 32'h50, rd & 32'h50);
    check_val("irq masked", 32'h0, 32'(conv_irq));
    // Disable powers down and clears the channel selection
    wr(sacc_pkg::OFF_CSA, 8'h00);
    repeat (3) @(posedge pclk);
    check_val("power down", 32'h0, 32'(ana.power_en));
    check_val("ch_sel down", 32'h0, 32'(ana.ch_sel));
    report_and_stop();
  end
endmodule
`default_nettype wire
